// ---- rtl/ssmd_pkg.sv ----
// package: layout of the status/control register map table words
package ssmd_pkg;

	// ************************************************************
	// table word indices
	// ************************************************************
	localparam logic [1:0] W_VOL_BASE = 2'h0;
	localparam logic [1:0] W_NVOL_BASE = 2'h1;
	localparam logic [1:0] W_CMD_BUSY = 2'h2;
	localparam logic [1:0] W_PROG_FAULT = 2'h3;

	// ************************************************************
	// generic command and busy word, lsb positions
	// ************************************************************
	localparam int CMD_RD_SUP = 31;
	localparam int CMD_WR_SUP = 30;
	localparam int CMD_LEN = 28;
	localparam int CMD_DUMMY_VOL = 23;
	localparam int CMD_DUMMY_NVOL = 18;
	localparam int BUSY_AVAIL = 17;
	localparam int BUSY_POL = 16;
	localparam int BUSY_ADDR_POS = 15;
	localparam int BUSY_BIT = 11;
	localparam int BUSY_ADDR = 3;
	localparam int CMD_RSVD = 0;
	localparam int CMD_RSVD_W = 3;

	// ************************************************************
	// program fault word, lsb positions
	// ************************************************************
	localparam int PERR_AVAIL = 31;
	localparam int PERR_POL = 30;
	localparam int PERR_ADDR_POS = 29;
	localparam int PERR_SHARED = 28;
	localparam int PERR_BIT = 24;
	localparam int PERR_ADDR = 16;
	localparam int PERR_RSVD = 0;
	localparam int PERR_RSVD_W = 16;

	// ************************************************************
	// encodings, reset values and read latency
	// ************************************************************
	localparam logic [1:0] CMD_LEN_6_BYTES = 2'h0;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam int READ_LATENCY = 1;

endpackage

// ---- rtl/ssmd_flag_pick.sv ----
// flag picker: selects one indicator bit and normalises its polarity
`timescale 1ns/1ps
module ssmd_flag_pick (
	// physical register contents
	input wire logic [15:0] reg_val_i,
	// indicator description
	input wire logic [3:0] bit_pos_i,
	input wire logic inverted_i,
	input wire logic avail_i,
	// result, one means busy or failed
	output logic flag_o
);
	// an unavailable indicator never reports, so a host polling it cannot hang
	assign flag_o = avail_i & (reg_val_i[bit_pos_i] ^ inverted_i);
endmodule

// ---- rtl/ssmd_decoder.sv ----
// status register map table: word server and busy / program fault tracker
//
// Behaviour
// - word 0 holds the 32-bit volatile register block base offset.
// - word 1 holds the 32-bit non-volatile register block base offset.
// - word 2 bit 31 flags generic register read support; host obeys it.
// - word 2 bit 30 flags generic register write support; host obeys it.
// - word 2 bits 29:28 give command-address length; only 00, six bytes.
// - word 2 bits 27:23 give volatile read dummy cycles, 0 to 31.
// - word 2 bits 22:18 give non-volatile read dummy cycles, 0 to 31.
// - word 2 bit 17 says a busy indicator exists; else host must not poll.
// - word 2 bits 14:11 give busy bit position in its register.
// - word 2 bits 10:3 give busy register local address.
// - reserved bits 2:0 of word 2 and 15:0 of word 3 read zero.
// - word 3 bit 31 flags a program fault indicator; else ignore fields.
// - word 3 bit 28 set when one bit reports program and erase faults.
// - word 3 bits 27:24 give program fault bit position.
// - word 3 bits 23:16 give program fault register local address.
`timescale 1ns/1ps
module ssmd_decoder
	import ssmd_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// table contents, captured on load_i
	input wire logic load_i,
	input wire logic [31:0] cfg_vol_base_i,
	input wire logic [31:0] cfg_nvol_base_i,
	input wire logic cfg_rd_sup_i,
	input wire logic cfg_wr_sup_i,
	input wire logic [4:0] cfg_dummy_vol_i,
	input wire logic [4:0] cfg_dummy_nvol_i,
	input wire logic cfg_busy_avail_i,
	input wire logic cfg_busy_pol_i,
	input wire logic cfg_busy_addr_pos_i,
	input wire logic [3:0] cfg_busy_bit_i,
	input wire logic [7:0] cfg_busy_addr_i,
	input wire logic cfg_perr_avail_i,
	input wire logic cfg_perr_pol_i,
	input wire logic cfg_perr_addr_pos_i,
	input wire logic cfg_perr_shared_i,
	input wire logic [3:0] cfg_perr_bit_i,
	input wire logic [7:0] cfg_perr_addr_i,
	// table word read port
	input wire logic rd_req_i,
	input wire logic [1:0] rd_index_i,
	output logic [31:0] rd_data_o,
	output logic rd_valid_o,
	// observed register reads
	input wire logic stat_valid_i,
	input wire logic [7:0] stat_addr_i,
	input wire logic [15:0] stat_data_i,
	// normalised indicator flags, busy fall pulse and load status
	output logic busy_o,
	output logic prog_fault_o,
	output logic busy_done_o,
	output logic loaded_o
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [31:0] vol_base;
		logic [31:0] nvol_base;
		logic [31:0] cmd_busy;
		logic [31:0] prog_fault;
		logic [31:0] rd_data;
		logic rd_valid;
		logic busy;
		logic prog_fault_flag;
		logic busy_done;
		logic loaded;
	} ssmd_state_t;

	ssmd_state_t cur;
	ssmd_state_t next_cur;
	logic busy_pick;
	logic perr_pick;
	logic busy_hit;
	logic perr_hit;

	// ************************************************************
	// indicator pickers
	// ************************************************************
	ssmd_flag_pick u_busy_pick (
		.reg_val_i(stat_data_i),
		.bit_pos_i(cur.cmd_busy[BUSY_BIT +: 4]),
		.inverted_i(cur.cmd_busy[BUSY_POL]),
		.avail_i(cur.cmd_busy[BUSY_AVAIL]),
		.flag_o(busy_pick)
	);

	ssmd_flag_pick u_perr_pick (
		.reg_val_i(stat_data_i),
		.bit_pos_i(cur.prog_fault[PERR_BIT +: 4]),
		.inverted_i(cur.prog_fault[PERR_POL]),
		.avail_i(cur.prog_fault[PERR_AVAIL]),
		.flag_o(perr_pick)
	);

	// an unavailable indicator is never tracked
	assign busy_hit = stat_valid_i & cur.loaded & cur.cmd_busy[BUSY_AVAIL]
		& (stat_addr_i == cur.cmd_busy[BUSY_ADDR +: 8]);
	assign perr_hit = stat_valid_i & cur.loaded & cur.prog_fault[PERR_AVAIL]
		& (stat_addr_i == cur.prog_fault[PERR_ADDR +: 8]);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_cur = cur;
		next_cur.rd_valid = 1'b0;
		next_cur.busy_done = 1'b0;
		if (load_i) begin
			next_cur.vol_base = cfg_vol_base_i;
			next_cur.nvol_base = cfg_nvol_base_i;
			next_cur.cmd_busy = WORD_RESET;
			next_cur.cmd_busy[CMD_RD_SUP] = cfg_rd_sup_i;
			next_cur.cmd_busy[CMD_WR_SUP] = cfg_wr_sup_i;
			// only one length is defined, so the field cannot carry anything else
			next_cur.cmd_busy[CMD_LEN +: 2] = CMD_LEN_6_BYTES;
			next_cur.cmd_busy[CMD_DUMMY_VOL +: 5] = cfg_dummy_vol_i;
			next_cur.cmd_busy[CMD_DUMMY_NVOL +: 5] = cfg_dummy_nvol_i;
			next_cur.cmd_busy[BUSY_AVAIL] = cfg_busy_avail_i;
			next_cur.cmd_busy[BUSY_POL] = cfg_busy_pol_i;
			next_cur.cmd_busy[BUSY_ADDR_POS] = cfg_busy_addr_pos_i;
			next_cur.cmd_busy[BUSY_BIT +: 4] = cfg_busy_bit_i;
			next_cur.cmd_busy[BUSY_ADDR +: 8] = cfg_busy_addr_i;
			next_cur.prog_fault = WORD_RESET;
			next_cur.prog_fault[PERR_AVAIL] = cfg_perr_avail_i;
			next_cur.prog_fault[PERR_POL] = cfg_perr_pol_i;
			next_cur.prog_fault[PERR_ADDR_POS] = cfg_perr_addr_pos_i;
			next_cur.prog_fault[PERR_SHARED] = cfg_perr_shared_i;
			next_cur.prog_fault[PERR_BIT +: 4] = cfg_perr_bit_i;
			next_cur.prog_fault[PERR_ADDR +: 8] = cfg_perr_addr_i;
			next_cur.loaded = 1'b1;
			next_cur.busy = 1'b0;
			next_cur.prog_fault_flag = 1'b0;
		end else begin
			if (busy_hit) begin
				next_cur.busy = busy_pick;
				next_cur.busy_done = cur.busy & ~busy_pick;
			end
			if (perr_hit) begin
				next_cur.prog_fault_flag = perr_pick;
			end
		end
		// reads see the words as they stood before any load in the same cycle
		if (rd_req_i) begin
			next_cur.rd_valid = 1'b1;
			case (rd_index_i)
				W_VOL_BASE: next_cur.rd_data = cur.vol_base;
				W_NVOL_BASE: next_cur.rd_data = cur.nvol_base;
				W_CMD_BUSY: next_cur.rd_data = cur.cmd_busy;
				W_PROG_FAULT: next_cur.rd_data = cur.prog_fault;
				default: next_cur.rd_data = WORD_RESET;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rd_data_o = cur.rd_data;
	assign rd_valid_o = cur.rd_valid;
	assign busy_o = cur.busy;
	assign prog_fault_o = cur.prog_fault_flag;
	assign busy_done_o = cur.busy_done;
	assign loaded_o = cur.loaded;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_load;
		load_i;
	endsequence

	sequence s_read_word2;
		rd_req_i && rd_index_i == W_CMD_BUSY && !load_i;
	endsequence

	property p_vol_base;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.vol_base == $past(cfg_vol_base_i);
	endproperty
	a_vol_base: assert property (p_vol_base) else $error("volatile base not captured");

	property p_nvol_read;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load ##1 (rd_req_i && rd_index_i == W_NVOL_BASE && !load_i)
			|=> rd_valid_o && rd_data_o == $past(cfg_nvol_base_i, 2);
	endproperty
	a_nvol_read: assert property (p_nvol_read) else $error("non-volatile base read wrong");

	property p_len_zero;
		@(posedge core_clk_i) disable iff (reset_i)
		s_read_word2 |=> rd_data_o[CMD_LEN +: 2] == CMD_LEN_6_BYTES;
	endproperty
	a_len_zero: assert property (p_len_zero) else $error("length code not 00");

	property p_dummy_vol;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.cmd_busy[CMD_DUMMY_VOL +: 5] == $past(cfg_dummy_vol_i)
			&& cur.cmd_busy[CMD_DUMMY_NVOL +: 5] == $past(cfg_dummy_nvol_i);
	endproperty
	a_dummy_vol: assert property (p_dummy_vol) else $error("dummy counts misplaced");

	property p_busy_field;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.cmd_busy[BUSY_BIT +: 4] == $past(cfg_busy_bit_i)
			&& cur.cmd_busy[BUSY_ADDR +: 8] == $past(cfg_busy_addr_i);
	endproperty
	a_busy_field: assert property (p_busy_field) else $error("busy location misplaced");

	property p_rsvd_zero;
		@(posedge core_clk_i) disable iff (reset_i)
		rd_valid_o && $past(rd_index_i) == W_CMD_BUSY |-> rd_data_o[CMD_RSVD +: CMD_RSVD_W] == 3'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("word 2 reserved bits set");

	property p_rsvd_perr;
		@(posedge core_clk_i) disable iff (reset_i)
		rd_valid_o && $past(rd_index_i) == W_PROG_FAULT
			|-> rd_data_o[PERR_RSVD +: PERR_RSVD_W] == 16'h0000;
	endproperty
	a_rsvd_perr: assert property (p_rsvd_perr) else $error("word 3 reserved bits set");

	property p_read_latency;
		@(posedge core_clk_i) disable iff (reset_i)
		rd_req_i |=> rd_valid_o ##1 !rd_valid_o || $past(rd_req_i);
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer timing wrong");

	property p_busy_norm;
		@(posedge core_clk_i) disable iff (reset_i)
		busy_hit && !load_i |=> busy_o == ($past(stat_data_i[cur.cmd_busy[BUSY_BIT +: 4]])
			^ cur.cmd_busy[BUSY_POL]);
	endproperty
	a_busy_norm: assert property (p_busy_norm) else $error("busy flag not normalised");

	property p_busy_unavail;
		@(posedge core_clk_i) disable iff (reset_i)
		cur.loaded && !cur.cmd_busy[BUSY_AVAIL] |-> !busy_o;
	endproperty
	a_busy_unavail: assert property (p_busy_unavail) else $error("busy set while unavailable");

	property p_perr_unavail;
		@(posedge core_clk_i) disable iff (reset_i)
		cur.loaded && !cur.prog_fault[PERR_AVAIL] |-> !prog_fault_o;
	endproperty
	a_perr_unavail: assert property (p_perr_unavail) else $error("fault set while unavailable");

	property p_perr_fields;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.prog_fault[PERR_BIT +: 4] == $past(cfg_perr_bit_i)
			&& cur.prog_fault[PERR_ADDR +: 8] == $past(cfg_perr_addr_i)
			&& cur.prog_fault[PERR_SHARED] == $past(cfg_perr_shared_i);
	endproperty
	a_perr_fields: assert property (p_perr_fields) else $error("fault location misplaced");

	property p_busy_done;
		@(posedge core_clk_i) disable iff (reset_i)
		busy_done_o |-> $past(busy_o) && !busy_o;
	endproperty
	a_busy_done: assert property (p_busy_done) else $error("busy done without fall");

	sequence s_busy_sample;
		busy_hit && !load_i;
	endsequence

	sequence s_perr_sample;
		perr_hit && !load_i;
	endsequence

	property p_rd_sup;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.cmd_busy[CMD_RD_SUP] == $past(cfg_rd_sup_i);
	endproperty
	a_rd_sup: assert property (p_rd_sup) else $error("read support bit misplaced");

	property p_wr_sup;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.cmd_busy[CMD_WR_SUP] == $past(cfg_wr_sup_i);
	endproperty
	a_wr_sup: assert property (p_wr_sup) else $error("write support bit misplaced");

	property p_busy_attr;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.cmd_busy[BUSY_AVAIL] == $past(cfg_busy_avail_i)
			&& cur.cmd_busy[BUSY_POL] == $past(cfg_busy_pol_i)
			&& cur.cmd_busy[BUSY_ADDR_POS] == $past(cfg_busy_addr_pos_i);
	endproperty
	a_busy_attr: assert property (p_busy_attr) else $error("busy attributes misplaced");

	property p_perr_attr;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> cur.prog_fault[PERR_AVAIL] == $past(cfg_perr_avail_i)
			&& cur.prog_fault[PERR_POL] == $past(cfg_perr_pol_i)
			&& cur.prog_fault[PERR_ADDR_POS] == $past(cfg_perr_addr_pos_i);
	endproperty
	a_perr_attr: assert property (p_perr_attr) else $error("fault attributes misplaced");

	property p_load_clears;
		@(posedge core_clk_i) disable iff (reset_i)
		s_load |=> loaded_o && !busy_o && !prog_fault_o;
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("load left a flag set");

	property p_cmd_read;
		@(posedge core_clk_i) disable iff (reset_i)
		s_read_word2 |=> rd_valid_o && rd_data_o == $past(cur.cmd_busy);
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("word 2 read wrong");

	property p_vol_read;
		@(posedge core_clk_i) disable iff (reset_i)
		rd_req_i && rd_index_i == W_VOL_BASE |=> rd_valid_o && rd_data_o == $past(cur.vol_base);
	endproperty
	a_vol_read: assert property (p_vol_read) else $error("volatile base read wrong");

	property p_perr_norm;
		@(posedge core_clk_i) disable iff (reset_i)
		s_perr_sample |=> prog_fault_o == ($past(stat_data_i[cur.prog_fault[PERR_BIT +: 4]])
			^ cur.prog_fault[PERR_POL]);
	endproperty
	a_perr_norm: assert property (p_perr_norm) else $error("fault flag not normalised");

	property p_busy_hold;
		@(posedge core_clk_i) disable iff (reset_i)
		!busy_hit && !load_i |=> $stable(busy_o);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy changed without sample");

	property p_perr_hold;
		@(posedge core_clk_i) disable iff (reset_i)
		!perr_hit && !load_i |=> $stable(prog_fault_o);
	endproperty
	a_perr_hold: assert property (p_perr_hold) else $error("fault changed without sample");

	property p_done_fall;
		@(posedge core_clk_i) disable iff (reset_i)
		s_busy_sample ##0 (busy_o && !busy_pick) |=> busy_done_o;
	endproperty
	a_done_fall: assert property (p_done_fall) else $error("busy fall not reported");

endmodule

// ---- bench/ssmd_host_model.sv ----
// host controller model: table word reads and status register results
`timescale 1ns/1ps
module ssmd_host_model (
	// clock
	input wire logic core_clk_i,
	// table word read port
	output logic rd_req_o,
	output logic [1:0] rd_index_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_valid_i,
	// observed register reads
	output logic stat_valid_o,
	output logic [7:0] stat_addr_o,
	output logic [15:0] stat_data_o
);
	initial begin
		rd_req_o = 1'b0;
		rd_index_o = 2'h0;
		stat_valid_o = 1'b0;
		stat_addr_o = 8'h00;
		stat_data_o = 16'h0000;
	end

	// ************************************************************
	// table access
	// ************************************************************
	// answer is registered on the taking edge and read at the next falling edge; index lines carry junk once released
	task automatic read_word(input logic [1:0] idx, output logic [31:0] data, output logic vld);
		@(negedge core_clk_i);
		rd_req_o = 1'b1;
		rd_index_o = idx;
		@(negedge core_clk_i);
		rd_req_o = 1'b0;
		rd_index_o = ~idx;
		vld = rd_valid_i;
		data = rd_data_i;
	endtask

	// ************************************************************
	// status register results
	// ************************************************************
	// inverted lines after release, so a stale value can never look like a fresh read
	task automatic show_status(input logic [7:0] addr, input logic [15:0] data);
		@(negedge core_clk_i);
		stat_valid_o = 1'b1;
		stat_addr_o = addr;
		stat_data_o = data;
		@(negedge core_clk_i);
		stat_valid_o = 1'b0;
		stat_addr_o = ~addr;
		stat_data_o = ~data;
	endtask

	// local address lands in byte 0 or byte 1 of the base offset
	function automatic logic [31:0] phys_addr(input logic [31:0] base, input logic [7:0] loc,
		input logic in_byte1);
		phys_addr = base + (in_byte1 ? {16'h0000, loc, 8'h00} : {24'h000000, loc});
	endfunction

	// registers mix several bits, so only the masked bits may change on write-back
	function automatic logic [15:0] merge_bits(input logic [15:0] old, input logic [15:0] mask,
		input logic [15:0] val);
		merge_bits = (old & ~mask) | (val & mask);
	endfunction
endmodule

// ---- bench/test_status_register_map_decoder.sv ----
// testbench: table load and read-back, busy and program fault tracking
`timescale 1ns/1ps
module test_status_register_map_decoder;
	import ssmd_pkg::*;
	logic core_clk_i;
	logic reset_i;
	logic load_i;
	logic [31:0] vb, nb, w2, w3;
	logic rd_req, rd_valid, stat_valid, busy, fault, done, loaded;
	logic [1:0] rd_index;
	logic [31:0] rd_data;
	logic [7:0] stat_addr;
	logic [15:0] stat_data;
	logic [31:0] word_seen;
	logic word_vld;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;

	ssmd_decoder dut_u (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .load_i(load_i),
		.cfg_vol_base_i(vb), .cfg_nvol_base_i(nb),
		.cfg_rd_sup_i(w2[31]), .cfg_wr_sup_i(w2[30]),
		.cfg_dummy_vol_i(w2[27:23]), .cfg_dummy_nvol_i(w2[22:18]),
		.cfg_busy_avail_i(w2[17]), .cfg_busy_pol_i(w2[16]), .cfg_busy_addr_pos_i(w2[15]),
		.cfg_busy_bit_i(w2[14:11]), .cfg_busy_addr_i(w2[10:3]),
		.cfg_perr_avail_i(w3[31]), .cfg_perr_pol_i(w3[30]), .cfg_perr_addr_pos_i(w3[29]),
		.cfg_perr_shared_i(w3[28]), .cfg_perr_bit_i(w3[27:24]), .cfg_perr_addr_i(w3[23:16]),
		.rd_req_i(rd_req), .rd_index_i(rd_index), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.stat_valid_i(stat_valid), .stat_addr_i(stat_addr), .stat_data_i(stat_data),
		.busy_o(busy), .prog_fault_o(fault), .busy_done_o(done), .loaded_o(loaded)
	);

	ssmd_host_model host_u (
		.core_clk_i(core_clk_i), .rd_req_o(rd_req), .rd_index_o(rd_index),
		.rd_data_i(rd_data), .rd_valid_i(rd_valid), .stat_valid_o(stat_valid),
		.stat_addr_o(stat_addr), .stat_data_o(stat_data)
	);

	// ************************************************************
	// clock, reset and watchdog
	// ************************************************************
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			$display("Error at %0t: run did not finish in time", $time);
			finish_test();
		end
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// load clears both flags
	task automatic load(input logic [31:0] v, input logic [31:0] n, input logic [31:0] a,
		input logic [31:0] b);
		@(negedge core_clk_i);
		vb = v;
		nb = n;
		w2 = a;
		w3 = b;
		load_i = 1'b1;
		@(negedge core_clk_i);
		load_i = 1'b0;
		check({loaded, busy, fault}, 32'h4);
	endtask

	// reserved and length bits must read zero whatever the inputs were
	task automatic read_all();
		logic [31:0] exp [4];
		logic [31:0] d;
		logic v;
		exp = '{vb, nb, w2 & 32'hcfff_fff8, w3 & 32'hffff_0000};
		for (int i = 0; i < 4; i++) begin
			host_u.read_word(i[1:0], d, v);
			check(v, 32'h1);
			check(d, exp[i]);
		end
	endtask

	task automatic sample(input logic [7:0] a, input logic [15:0] d, input logic [2:0] exp);
		host_u.show_status(a, d);
		check({busy, fault, done}, exp);
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		reset_i = 1'b1;
		load_i = 1'b0;
		vb = 32'h0;
		nb = 32'h0;
		w2 = 32'h0;
		w3 = 32'h0;
		repeat (4) @(negedge core_clk_i);
		reset_i = 1'b0;
		read_all();
		check(loaded, 0);
		$display("test 1 done: empty table after reset");
		// busy positive at bit 10 of 8'h5c, fault inverted at bit 3 of 8'ha7
		load(32'h1234_5678, 32'h9abc_def0, 32'hbf82_d2e7, 32'hd3a7_ffff);
		read_all();
		host_u.read_word(W_CMD_BUSY, word_seen, word_vld);
		check(host_u.phys_addr(vb, word_seen[10:3], word_seen[15]), 32'h1234_b278);
		host_u.read_word(W_PROG_FAULT, word_seen, word_vld);
		check(host_u.phys_addr(nb, word_seen[23:16], word_seen[29]), 32'h9abc_df97);
		sample(8'h5c, host_u.merge_bits(16'h0000, 16'h0400, 16'hffff), 3'b100);
		sample(8'h5d, 16'h0000, 3'b100);
		sample(8'ha7, 16'hfff7, 3'b110);
		sample(8'h5c, 16'hfbff, 3'b011);
		$display("test 2 done: positive busy, inverted fault");
		// busy inverted at bit 15 of 8'h00, fault unavailable at the same address
		load(32'hffff_ff00, 32'h0000_0100, 32'h407f_7800, 32'h6f00_1234);
		read_all();
		sample(8'h00, 16'h7fff, 3'b100);
		sample(8'h00, 16'h8000, 3'b001);
		$display("test 3 done: inverted busy, fault unavailable");
		// busy unavailable, positive fault at bit 0 of 8'h00
		load(32'h0, 32'h0, 32'h0000_0000, 32'h8000_0000);
		read_all();
		sample(8'h00, 16'hffff, 3'b010);
		sample(8'h00, 16'hfffe, 3'b000);
		$display("test 4 done: busy unavailable");
		finish_test();
	end
endmodule
